// ---- src/idr_pkg.sv ----
// Constants, register map and types for the identify response builder
// Contract
// - exit latency word in bits 95:64
// - entry latency word in bits 63:32
// - bit 25 flags non-operational power state
// - bit 24 selects power step size
// - bits 15:0 hold maximum power value
// - selector 02h lists active ids ascending, greater
// - abort list for ids FFFFFFFEh, FFFFFFFFh
// - namespace id zero lists from id 1
// - selector 03h returns descriptors of active namespace
// - descriptors packed within 4096-byte payload
// - payload bytes after last descriptor are zero
// - never repeat a descriptor type
// - always include one identifying descriptor
// - type fixes kind and length; never 0h
// - type, length, two reserved, then identifier
// - type 1h only when extended id nonzero
// - type 2h only when global uid nonzero
// - type 3h whenever neither other id exists
package idr_pkg;
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_CMD_NAMESPACE_ID = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_RESP_INDEX = 12'h00C;
	localparam logic [11:0] OFS_PSD_W0 = 12'h010;
	localparam logic [11:0] OFS_PSD_W1 = 12'h014;
	localparam logic [11:0] OFS_PSD_W2 = 12'h018;
	localparam logic [11:0] OFS_NS_ACTIVE = 12'h01C;
	localparam logic [11:0] OFS_NS_SEL = 12'h020;
	localparam logic [11:0] OFS_NS_DATA = 12'h024;
	localparam logic [11:0] OFS_RESP_DATA = 12'h028;
	// Power descriptor field positions
	localparam int POS_NON_OP = 25;
	localparam int POS_SCALE = 24;
	localparam int MAXP_W = 16;
	// Identify selectors
	localparam logic [7:0] SEL_ACTIVE_LIST = 8'h02;
	localparam logic [7:0] SEL_DESC_LIST = 8'h03;
	// Completion status codes
	localparam logic [7:0] ST_SUCCESS = 8'h00;
	localparam logic [7:0] ST_BAD_FIELD = 8'h02;
	localparam logic [7:0] ST_BAD_NAMESPACE = 8'h0B;
	// Namespace store geometry
	localparam int NS_MAX = 4;
	localparam int NS_WORDS = 10;
	localparam int PAY_WORDS = 1024;
	localparam logic [31:0] NAMESPACE_ID_RSVD_LO = 32'hFFFFFFFE;
	// Word slots inside one namespace record
	localparam logic [3:0] W_EUI = 4'h0;
	localparam logic [3:0] W_GUID = 4'h2;
	localparam logic [3:0] W_UUID = 4'h6;
	// Descriptor types and identifier lengths in bytes
	localparam logic [7:0] TYPE_EUI = 8'h01;
	localparam logic [7:0] TYPE_GUID = 8'h02;
	localparam logic [7:0] TYPE_UUID = 8'h03;
	localparam logic [7:0] LEN_EUI = 8'h08;
	localparam logic [7:0] LEN_UID = 8'h10;
	// Descriptor sizes in payload words, header included
	localparam logic [9:0] SPAN_EUI = 10'h003;
	localparam logic [9:0] SPAN_UID = 10'h005;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [9:0] RST_INDEX = 10'h000;
	// Command engine states
	typedef enum logic [1:0] {IDR_IDLE, IDR_CHECK, IDR_DONE} idr_state_e;
endpackage

// ---- src/idr_pack_if.sv ----
// Carrier between the top and the descriptor packer
`timescale 1ns/1ps
`default_nettype none
interface idr_pack_if;
	logic has_eui;
	logic has_guid;
	logic has_uuid;
	logic [9:0] word_idx;
	logic is_hdr;
	logic is_zero;
	logic [7:0] hdr_type;
	logic [7:0] hdr_len;
	logic [3:0] id_word;
	modport top (output has_eui, has_guid, has_uuid, word_idx,
		input is_hdr, is_zero, hdr_type, hdr_len, id_word);
	modport packer (input has_eui, has_guid, has_uuid, word_idx,
		output is_hdr, is_zero, hdr_type, hdr_len, id_word);
endinterface
`default_nettype wire

// ---- src/idr_desc_packer.sv ----
// Maps a payload word index to the descriptor list layout
`timescale 1ns/1ps
`default_nettype none
module idr_desc_packer (
	// Layout request and answer
	idr_pack_if.packer pk
);
	import idr_pkg::*;

	// True when idx falls inside a slot starting at base
	function automatic logic in_slot(input logic [9:0] idx,
		input logic [9:0] base, input logic [9:0] span);
		in_slot = (idx >= base) && (idx < base + span);
	endfunction

	wire logic [9:0] base_guid;
	wire logic [9:0] base_uuid;
	wire logic hit_eui;
	wire logic hit_guid;
	wire logic hit_uuid;
	wire logic [9:0] rel;
	wire logic [9:0] rel_m1;

	// Present types packed back to back, each at most once
	assign base_guid = pk.has_eui ? SPAN_EUI : 10'h000;
	assign base_uuid = base_guid + (pk.has_guid ? SPAN_UID : 10'h000);
	assign hit_eui = pk.has_eui && in_slot(pk.word_idx, 10'h000, SPAN_EUI);
	assign hit_guid = pk.has_guid && in_slot(pk.word_idx, base_guid, SPAN_UID);
	assign hit_uuid = pk.has_uuid && in_slot(pk.word_idx, base_uuid, SPAN_UID);
	assign rel = hit_eui ? pk.word_idx :
		hit_guid ? pk.word_idx - base_guid : pk.word_idx - base_uuid;
	assign rel_m1 = rel - 10'h001;

	// First word of a slot is the header; rest is identifier
	assign pk.is_hdr = (hit_eui || hit_guid || hit_uuid) && rel == 10'h000;
	// Everything past the last descriptor reads zero
	assign pk.is_zero = !(hit_eui || hit_guid || hit_uuid);
	// Type carries kind and length; reserved type 0 never made
	assign pk.hdr_type = hit_eui ? TYPE_EUI :
		hit_guid ? TYPE_GUID : TYPE_UUID;
	assign pk.hdr_len = hit_eui ? LEN_EUI : LEN_UID;
	assign pk.id_word = (hit_eui ? W_EUI : hit_guid ? W_GUID : W_UUID)
		+ rel_m1[3:0];
endmodule
`default_nettype wire

// ---- src/idr_top.sv ----
// Identify response builder: APB registers, command checks, payload
`timescale 1ns/1ps
`default_nettype none
module idr_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [idr_pkg::ADDR_W-1:0] paddr,
	input wire logic [idr_pkg::DATA_W-1:0] pwdata,
	output logic [idr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import idr_pkg::*;

	// Record word position of namespace ns, word w
	function automatic logic [5:0] mem_index(input logic [1:0] ns,
		input logic [3:0] w);
		mem_index = 6'(ns) * 6'(NS_WORDS) + 6'(w);
	endfunction

	// n-th active id above floor, zero when list runs out
	function automatic logic [31:0] nth_active(input logic [3:0] act,
		input logic [31:0] floor, input logic [9:0] n);
		logic [9:0] cnt;
		cnt = 10'h000;
		nth_active = 32'h00000000;
		for (int j = 1; j <= NS_MAX; j++) begin
			if (act[j-1] && 32'(j) > floor) begin
				if (cnt == n) begin
					nth_active = 32'(j);
				end
				cnt = cnt + 10'h001;
			end
		end
	endfunction

	// Namespace identity store
	logic [31:0] ns_mem [NS_MAX*NS_WORDS];

	// Software visible state
	logic [7:0] selector;
	logic [31:0] cmd_namespace_id;
	logic [9:0] resp_index;
	logic [31:0] exit_lat;
	logic [31:0] entry_lat;
	logic non_op;
	logic scale_sel;
	logic [MAXP_W-1:0] max_power;
	logic [NS_MAX-1:0] ns_active;
	logic [1:0] sel_ns;
	logic [3:0] sel_word;
	idr_state_e state;
	logic [7:0] status_code;
	// Snapshots taken when a command is checked
	logic [3:0] snap_active;
	logic [1:0] snap_ns;
	logic snap_eui;
	logic snap_guid;
	logic snap_uuid;

	idr_pack_if pk_if ();

	idr_desc_packer u_packer (
		.pk(pk_if.packer)
	);

	// Bus phase decode
	wire logic acc_first;
	wire logic acc_done;
	wire logic wr_done;
	wire logic rd_done;
	wire logic [11:0] addr;
	wire logic hit_cmd;
	wire logic hit_namespace_id;
	wire logic hit_status;
	wire logic hit_index;
	wire logic hit_w0;
	wire logic hit_w1;
	wire logic hit_w2;
	wire logic hit_act;
	wire logic hit_sel;
	wire logic hit_data;
	wire logic hit_resp;
	wire logic mapped;
	// One wait state: read data is latched on the edge that raises pready; writes commit on the next edge
	assign acc_first = psel && penable && !pready;
	assign acc_done = psel && penable && pready;
	assign wr_done = acc_done && pwrite && mapped;
	assign rd_done = acc_done && !pwrite && mapped;
	assign addr = paddr[11:0];
	assign hit_cmd = addr == OFS_CMD;
	assign hit_namespace_id = addr == OFS_CMD_NAMESPACE_ID;
	assign hit_status = addr == OFS_STATUS;
	assign hit_index = addr == OFS_RESP_INDEX;
	assign hit_w0 = addr == OFS_PSD_W0;
	assign hit_w1 = addr == OFS_PSD_W1;
	assign hit_w2 = addr == OFS_PSD_W2;
	assign hit_act = addr == OFS_NS_ACTIVE;
	assign hit_sel = addr == OFS_NS_SEL;
	assign hit_data = addr == OFS_NS_DATA;
	assign hit_resp = addr == OFS_RESP_DATA;
	assign mapped = hit_cmd || hit_namespace_id || hit_status || hit_index ||
		hit_w0 || hit_w1 || hit_w2 || hit_act || hit_sel || hit_data ||
		hit_resp;

	// Per-register strobes, each true in the committing cycle only
	wire logic wr_cmd;
	wire logic wr_namespace_id;
	wire logic wr_index;
	wire logic wr_w0;
	wire logic wr_w1;
	wire logic wr_w2;
	wire logic wr_act;
	wire logic wr_sel;
	wire logic wr_data;
	wire logic rd_resp;
	assign wr_cmd = wr_done && hit_cmd;
	assign wr_namespace_id = wr_done && hit_namespace_id;
	assign wr_index = wr_done && hit_index;
	assign wr_w0 = wr_done && hit_w0;
	assign wr_w1 = wr_done && hit_w1;
	assign wr_w2 = wr_done && hit_w2;
	assign wr_act = wr_done && hit_act;
	assign wr_sel = wr_done && hit_sel;
	assign wr_data = wr_done && hit_data;
	assign rd_resp = rd_done && hit_resp;

	// Command engine phase as seen by the bus side
	wire logic cmd_busy;
	wire logic cmd_done;
	assign cmd_busy = state == IDR_CHECK;
	assign cmd_done = state == IDR_DONE;

	// Words past the record are dropped rather than aliasing a neighbour
	wire logic store_wr;
	assign store_wr = wr_data && sel_word < 4'(NS_WORDS);
	// NAMESPACE_ID is frozen while a command is being checked
	wire logic namespace_id_load;
	assign namespace_id_load = wr_namespace_id && !cmd_busy;

	// Command namespace lookup
	wire logic [1:0] cmd_ns;
	wire logic cmd_ns_ok;
	wire logic [31:0] eui_lo;
	wire logic [31:0] eui_hi;
	wire logic [31:0] guid_or;
	wire logic [31:0] uuid_or;
	wire logic has_eui;
	wire logic has_guid;
	assign cmd_ns = 2'(cmd_namespace_id - 32'h00000001);
	assign cmd_ns_ok = cmd_namespace_id != 32'h00000000 &&
		cmd_namespace_id <= 32'(NS_MAX) && ns_active[cmd_ns];
	assign eui_lo = ns_mem[mem_index(cmd_ns, W_EUI)];
	assign eui_hi = ns_mem[mem_index(cmd_ns, W_EUI + 4'h1)];
	assign guid_or = ns_mem[mem_index(cmd_ns, W_GUID)] |
		ns_mem[mem_index(cmd_ns, W_GUID + 4'h1)] |
		ns_mem[mem_index(cmd_ns, W_GUID + 4'h2)] |
		ns_mem[mem_index(cmd_ns, W_GUID + 4'h3)];
	assign uuid_or = ns_mem[mem_index(cmd_ns, W_UUID)] |
		ns_mem[mem_index(cmd_ns, W_UUID + 4'h1)] |
		ns_mem[mem_index(cmd_ns, W_UUID + 4'h2)] |
		ns_mem[mem_index(cmd_ns, W_UUID + 4'h3)];
	// Zero identifiers mean unsupported and are left out
	assign has_eui = (eui_lo | eui_hi) != 32'h00000000;
	assign has_guid = guid_or != 32'h00000000;

	// UUID whenever nothing else identifies the namespace
	wire logic has_uuid;
	wire logic next_snap_uuid;
	assign has_uuid = uuid_or != 32'h00000000;
	assign next_snap_uuid = (!has_eui && !has_guid) || has_uuid;

	// Status of a freshly checked command
	wire logic [7:0] next_status;
	assign next_status =
		(selector == SEL_ACTIVE_LIST) ?
		(cmd_namespace_id >= NAMESPACE_ID_RSVD_LO ? ST_BAD_NAMESPACE : ST_SUCCESS) :
		(selector == SEL_DESC_LIST) ?
		(cmd_ns_ok ? ST_SUCCESS : ST_BAD_NAMESPACE) : ST_BAD_FIELD;

	// Layout request to the packer
	assign pk_if.has_eui = snap_eui;
	assign pk_if.has_guid = snap_guid;
	assign pk_if.has_uuid = snap_uuid;
	assign pk_if.word_idx = resp_index;

	// Payload word at the response index
	wire logic resp_ok;
	wire logic [31:0] desc_word;
	wire logic [31:0] resp_word;
	assign resp_ok = cmd_done && status_code == ST_SUCCESS;
	assign desc_word = pk_if.is_zero ? 32'h00000000 :
		pk_if.is_hdr ? {16'h0000, pk_if.hdr_len, pk_if.hdr_type} :
		ns_mem[mem_index(snap_ns, pk_if.id_word)];
	// Zero floor already yields a list starting at id 1
	assign resp_word = !resp_ok ? 32'h00000000 :
		selector == SEL_ACTIVE_LIST ?
		nth_active(snap_active, cmd_namespace_id, resp_index) :
		desc_word;

	// Read views of the composite registers
	wire logic [31:0] status_view;
	wire logic [31:0] index_view;
	wire logic [31:0] psd_view;
	wire logic [31:0] active_view;
	wire logic [31:0] select_view;
	wire logic [31:0] store_view;
	assign status_view = {16'h0000, status_code, 6'h00, cmd_done, cmd_busy};
	assign index_view = {22'h000000, resp_index};
	// Reserved power bits are not stored, so they can only read zero
	assign psd_view = {6'h00, non_op, scale_sel, 8'h00, max_power};
	assign active_view = {28'h0000000, ns_active};
	assign select_view = {20'h00000, sel_word, 6'h00, sel_ns};
	assign store_view = ns_mem[mem_index(sel_ns, sel_word)];

	// Read data mux; unmapped offsets read zero
	wire logic [31:0] rd_word;
	assign rd_word =
		hit_cmd ? {24'h000000, selector} :
		hit_namespace_id ? cmd_namespace_id :
		hit_status ? status_view :
		hit_index ? index_view :
		hit_w0 ? psd_view :
		hit_w1 ? entry_lat :
		hit_w2 ? exit_lat :
		hit_act ? active_view :
		hit_sel ? select_view :
		hit_data ? store_view :
		hit_resp ? resp_word : 32'h00000000;

	// APB answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_WORD;
		end else begin
			pready <= acc_first;
			pslverr <= acc_first && !mapped;
			if (acc_first) begin
				prdata <= pwrite ? RST_WORD : rd_word;
			end
		end
	end

	// Power descriptor fields, stored without reserved bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exit_lat <= RST_WORD;
			entry_lat <= RST_WORD;
			non_op <= 1'b0;
			scale_sel <= 1'b0;
			max_power <= 16'h0000;
		end else begin
			if (wr_w2) begin
				exit_lat <= pwdata;
			end
			if (wr_w1) begin
				entry_lat <= pwdata;
			end
			if (wr_w0) begin
				non_op <= pwdata[POS_NON_OP];
				scale_sel <= pwdata[POS_SCALE];
				max_power <= pwdata[MAXP_W-1:0];
			end
		end
	end

	// Namespace table set-up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ns_active <= 4'h0;
			sel_ns <= 2'h0;
			sel_word <= 4'h0;
		end else begin
			if (wr_act) begin
				ns_active <= pwdata[NS_MAX-1:0];
			end
			if (wr_sel) begin
				sel_ns <= pwdata[1:0];
				sel_word <= pwdata[11:8];
			end
		end
	end

	// Identity store has no reset; software loads it first
	always_ff @(posedge pclk) begin
		if (store_wr) begin
			ns_mem[mem_index(sel_ns, sel_word)] <= pwdata;
		end
	end

	// Response index: software load wins over the read step
	wire logic [9:0] next_resp_index;
	assign next_resp_index = wr_index ? pwdata[9:0] :
		rd_resp ? resp_index + 10'h001 : resp_index;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_index <= RST_INDEX;
		end else begin
			resp_index <= next_resp_index;
		end
	end

	// Command engine; a start while checking is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= IDR_IDLE;
			selector <= 8'h00;
			cmd_namespace_id <= RST_WORD;
			status_code <= ST_SUCCESS;
			snap_active <= 4'h0;
			snap_ns <= 2'h0;
			snap_eui <= 1'b0;
			snap_guid <= 1'b0;
			snap_uuid <= 1'b0;
		end else begin
			if (namespace_id_load) begin
				cmd_namespace_id <= pwdata;
			end
			case (state)
				IDR_IDLE, IDR_DONE: begin
					if (wr_cmd) begin
						selector <= pwdata[7:0];
						state <= IDR_CHECK;
					end
				end
				IDR_CHECK: begin
					status_code <= next_status;
					snap_active <= ns_active;
					snap_ns <= cmd_ns;
					snap_eui <= has_eui;
					snap_guid <= has_guid;
					snap_uuid <= next_snap_uuid;
					state <= IDR_DONE;
				end
				default: begin
					state <= IDR_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- sim/idr_top_checker.sv ----
// Bus timing and field assertions for the identify builder
`timescale 1ns/1ps
`default_nettype none
module idr_top_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [idr_pkg::ADDR_W-1:0] paddr,
	input wire logic [idr_pkg::DATA_W-1:0] pwdata,
	input wire logic [idr_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import idr_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Answer is a single pulse after exactly one wait state
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait");
	ready_cause_a: assert property (pready |->
		psel && penable && $past(psel && penable))
		else $error("pready without access phase");
	// Error answers carry no data; writes return zero
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	err_zero_a: assert property (pslverr |-> prdata == 32'h00000000)
		else $error("data on error answer");
	write_quiet_a: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("data on write answer");
	// Map decode: holes and misaligned refused, listed words accepted
	unmapped_a: assert property (pready && (paddr[1:0] != 2'b00 ||
		paddr > OFS_RESP_DATA) |-> pslverr)
		else $error("unmapped access accepted");
	mapped_ok_a: assert property (pready && paddr[1:0] == 2'b00 &&
		paddr <= OFS_RESP_DATA |-> !pslverr)
		else $error("mapped access refused");
	psd_rsvd_a: assert property (
		pready && !pwrite && paddr == OFS_PSD_W0 |->
		prdata[31:26] == 6'h00 && prdata[23:16] == 8'h00)
		else $error("reserved power bits set");
endmodule
bind idr_top idr_top_checker chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
`default_nettype wire

// ---- sim/idr_host_model.sv ----
// Host-side APB master that issues identify requests
`timescale 1ns/1ps
`default_nettype none
module idr_host_model (
	// Clock
	input wire logic pclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// One transfer; request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed; only the bench watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Stale data would hide decode faults
	endtask
endmodule
`default_nettype wire

// ---- sim/identify_response_builder_tb.sv ----
// Self-checking bench for the identify response builder
`timescale 1ns/1ps
`default_nettype none
module identify_response_builder_tb;
	import idr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [31:0] mem [4][10];
	logic [31:0] expw [16];
	logic [31:0] got [16];
	logic [9:0] keep [4] = '{10'h003, 10'h03C, 10'h000, 10'h3FF};
	logic [3:0] act = 4'b1101;
	logic [255:0] seen;
	logic [31:0] fl [6] = '{0, 1, 2, 3, 4, 32'h80000000};
	int bad_count = 0;
	int n_compared = 0;
	int seed = 32'h1651;
	int k;
	// Clock at 10 MHz
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	idr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	idr_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	task complete_run;
		$display("compared %0d wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] w);
		n_compared++;
		if (g !== w) begin
			bad_count++;
			$display("wrong value at %0t: %h vs %h", $time, g, w);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		host.xfer(1'b1, a, v, rd, er);
	endtask
	task rdr(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0, rd, er);
	endtask
	// Issue a command, wait for done, rewind the payload index
	task run(input logic [7:0] s, input logic [31:0] ns,
		input logic [7:0] code);
		wr(OFS_CMD_NAMESPACE_ID, ns);
		wr(OFS_CMD, {24'h0, s});
		for (int i = 0; i < 8 && rd[1] !== 1'b1; i++) begin
			rdr(OFS_STATUS);
		end
		check({31'h0, rd[1]}, 32'h1);
		check({24'h0, rd[15:8]}, {24'h0, code});
		wr(OFS_RESP_INDEX, 32'h0);
	endtask
	// Expected active list above a floor
	function void mklist(logic [31:0] f);
		expw = '{default: 32'h0};
		k = 0;
		for (int i = 1; i <= 4; i++) begin
			if (act[i-1] && i > f) begin
				expw[k] = i;
				k++;
			end
		end
	endfunction
	function void put(int n, logic [7:0] t, logic [7:0] l, int w0);
		expw[k] = {16'h0, l, t};
		for (int i = 0; i < l / 4; i++) begin
			expw[k+1+i] = mem[n][w0+i];
		end
		k = k + 1 + l / 4;
	endfunction
	// Expected descriptor list of one namespace
	function void mkdesc(int n);
		logic eu, gu, uu;
		expw = '{default: 32'h0};
		k = 0;
		eu = |{mem[n][0], mem[n][1]};
		gu = |{mem[n][2], mem[n][3], mem[n][4], mem[n][5]};
		uu = |{mem[n][6], mem[n][7], mem[n][8], mem[n][9]};
		if (eu) put(n, TYPE_EUI, LEN_EUI, 0);
		if (gu) put(n, TYPE_GUID, LEN_UID, 2);
		if (!eu && !gu || uu) put(n, TYPE_UUID, LEN_UID, 6);
	endfunction
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		complete_run;
	end
	initial begin
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Power descriptor words, all-ones corner first
		for (int i = 0; i < 6; i++) begin
			d = i == 0 ? 32'hFFFFFFFF : $random(seed);
			wr(OFS_PSD_W0, d);
			rdr(OFS_PSD_W0);
			check(rd, d & 32'h0300FFFF);
			wr(OFS_PSD_W1, ~d);
			rdr(OFS_PSD_W1);
			check(rd, ~d);
			wr(OFS_PSD_W2, d);
			rdr(OFS_PSD_W2);
			check(rd, d);
		end
		rdr(12'h02C);
		check({31'h0, er}, 32'h1);
		rdr(12'h006);
		check({31'h0, er}, 32'h1);
		// Identity store: EUI only, GUID only, none, all three
		for (int n = 0; n < 4; n++) begin
			for (int w = 0; w < 10; w++) begin
				mem[n][w] = keep[n][w] ? $random(seed) : 32'h0;
				wr(OFS_NS_SEL, w * 256 + n);
				wr(OFS_NS_DATA, mem[n][w]);
			end
		end
		wr(OFS_NS_ACTIVE, {28'h0, act});
		for (int j = 0; j < 6; j++) begin
			run(SEL_ACTIVE_LIST, fl[j], ST_SUCCESS);
			mklist(fl[j]);
			for (int i = 0; i < 6; i++) begin
				rdr(OFS_RESP_DATA);
				check(rd, expw[i]);
			end
		end
		run(SEL_ACTIVE_LIST, 32'hFFFFFFFE, ST_BAD_NAMESPACE);
		run(SEL_ACTIVE_LIST, 32'hFFFFFFFF, ST_BAD_NAMESPACE);
		run(8'h05, 32'h1, ST_BAD_FIELD);
		run(SEL_DESC_LIST, 32'h0, ST_BAD_NAMESPACE);
		for (int n = 0; n < 4; n++) begin
			run(SEL_DESC_LIST, n + 1,
				act[n] ? ST_SUCCESS : ST_BAD_NAMESPACE);
			if (act[n]) begin
				mkdesc(n);
				for (int i = 0; i < 16; i++) begin
					rdr(OFS_RESP_DATA);
					got[i] = rd;
					check(rd, expw[i]);
				end
				// Parse as the host would
				k = 0;
				seen = '0;
				while (k < 16 && got[k][15:8] != 8'h00) begin
					check({31'h0, got[k][7:0] == 8'h0 ||
						seen[got[k][7:0]]}, 32'h0);
					seen[got[k][7:0]] = 1'b1;
					k = k + 1 + got[k][15:10];
				end
				check({31'h0, seen[3:1] != 3'b000}, 32'h1);
				wr(OFS_RESP_INDEX, 32'h3FF);
				rdr(OFS_RESP_DATA);
				check(rd, 32'h0);
			end
		end
		complete_run;
	end
endmodule
`default_nettype wire
